// *** rtl/sacr_map.svh ***
// offsets, field positions, reset values and timing counts of the servo option registers
`ifndef SACR_MAP_SVH
`define SACR_MAP_SVH

`define SACR_OFS_PREC     8'h3e
`define SACR_OFS_OPT      8'h3f
`define SACR_OFS_AUX      8'h40
`define SACR_OFS_STAT     8'h41

`define SACR_RST_PREC     16'h0000
`define SACR_RST_OPT      16'h0000
`define SACR_RST_AUX      16'h0000
`define SACR_MASK_PREC    16'hffdf
`define SACR_MASK_OPT     16'h7772
`define SACR_MASK_AUX     16'h000f

// precision and pin direction register
`define SACR_F1N 15
`define SACR_F1D 14
`define SACR_F3N 13
`define SACR_F3D 12
`define SACR_T1N 11
`define SACR_T1U 10
`define SACR_T3N 9
`define SACR_T3U 8
`define SACR_HSRC 7
`define SACR_CMSK 6
`define SACR_LKX 4
`define SACR_COX 3
`define SACR_ALLX 2
`define SACR_MIRX 1
`define SACR_BYP 0
// clock and agc option register
`define SACR_ALT 14
`define SACR_DIV4 13
`define SACR_DIV2 12
`define SACR_CLRU 10
`define SACR_CLRL 9
`define SACR_CLRLU 8
`define SACR_FGN 6
`define SACR_SLQ 5
`define SACR_LPW 4
`define SACR_HALF 1
// aux register
`define SACR_SHOT 0
`define SACR_SLSRC 1
`define SACR_THSRC 2
`define SACR_TCC 3

`define SACR_HOLD_ADDR_DEF 6'h05
`define SACR_HOLD_ADDR_ALT 6'h04
`define SACR_RAM_LO_BASE   6'h00
`define SACR_RAM_UP_BASE   6'h08

`define SACR_CLK_NS        10
`define SACR_CLR_HOLD_NS   50000
`define SACR_CLR_HOLD_CYC  ((`SACR_CLR_HOLD_NS + `SACR_CLK_NS - 1) / `SACR_CLK_NS)

`endif

// *** rtl/sacr_pkg.sv ***
// types shared by the servo option register block
package sacr_pkg;
    typedef enum logic [2:0] {
        SACR_AMP_1_64,
        SACR_AMP_1_36,
        SACR_AMP_1_32,
        SACR_AMP_1_16,
        SACR_AMP_1_8
    } sacr_amp_t;
    typedef enum logic [1:0] {
        SACR_DIV_1,
        SACR_DIV_2,
        SACR_DIV_4
    } sacr_div_t;
endpackage

// *** rtl/sacr_top.sv ***
// servo option registers: precision, pin direction, clock division, agc test, ram clear
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`include "sacr_map.svh"
module sacr_top #(
    parameter int CLR_HOLD_CYC = `SACR_CLR_HOLD_CYC
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    // filter precision
    output logic                   focus_stage1_precise_normal,
    output logic                   focus_stage1_precise_down,
    output logic                   focus_stage3_precise_normal,
    output logic                   focus_stage3_precise_down,
    output logic                   track_stage1_precise_normal,
    output logic                   track_stage1_precise_up,
    output logic                   track_stage3_precise_normal,
    output logic                   track_stage3_precise_up,
    // filter input routing
    output logic [5:0]             focus_hold_src_addr,
    output logic                   sled_src_from_track,
    output logic                   trkhold_src_from_track,
    output logic                   center_correction_en,
    // internally generated detector signals
    input  wire logic              lock_int,
    input  wire logic              cross_int,
    input  wire logic              mirror_int,
    input  wire logic              defect_int,
    input  wire logic              focus_ok_int,
    // two-way detector pins
    input  wire logic              lock_pin_in,
    output logic                   lock_pin_out,
    output logic                   lock_pin_oe_n,
    input  wire logic              cross_pin_in,
    output logic                   cross_pin_out,
    output logic                   cross_pin_oe_n,
    input  wire logic              mirror_pin_in,
    output logic                   mirror_pin_out,
    output logic                   mirror_pin_oe_n,
    input  wire logic              defect_pin_in,
    output logic                   defect_pin_out,
    output logic                   defect_pin_oe_n,
    input  wire logic              focus_ok_pin_in,
    output logic                   focus_ok_pin_out,
    output logic                   focus_ok_pin_oe_n,
    // detector signals in use
    output logic                   lock_eff,
    output logic                   cross_eff,
    output logic                   mirror_detect,
    output logic                   defect_detect,
    output logic                   focus_ok,
    // servo master clock
    input  wire logic              clk_div_select_pin,
    output sacr_pkg::sacr_div_t    clk_div_ratio,
    output logic                   servo_master_clk,
    // agc test sine
    input  wire logic              agc_focus_amp_sel,
    input  wire logic              agc_track_amp_sel,
    output sacr_pkg::sacr_amp_t    agc_focus_amp,
    output sacr_pkg::sacr_amp_t    agc_track_amp,
    output logic                   agc_sine_step,
    // data ram clear port
    output logic                   ram_clr_we,
    output logic [5:0]             ram_clr_addr,
    output logic [15:0]            ram_clr_data,
    // anti-shock and focus search
    input  wire logic              shock_active,
    input  wire logic              shock_detect,
    output logic                   focus_force_gain_normal,
    output logic                   search_step,
    output logic                   shared_buffer_low_power,
    output logic                   shock_flag_pin_out,
    output logic                   shock_flag_pin_oe_n
);
    import sacr_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // common amplitude table
    function automatic sacr_amp_t amp_f(input logic alt, input logic f_sel,
                                        input logic t_sel, input logic track);
        sacr_amp_t a;
        a = SACR_AMP_1_16;
        if (alt) begin
            case ({f_sel, t_sel})
                2'b00:   a = SACR_AMP_1_64;
                2'b01:   a = SACR_AMP_1_32;
                2'b10:   a = SACR_AMP_1_16;
                default: a = SACR_AMP_1_8;
            endcase
        end else if (track) begin
            a = t_sel ? SACR_AMP_1_8 : SACR_AMP_1_16;
        end else begin
            a = f_sel ? SACR_AMP_1_16 : SACR_AMP_1_36;
        end
        return a;
    endfunction

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    logic [15:0] prec_q, prec_d;
    logic [15:0] opt_q, opt_d;
    logic [15:0] aux_q, aux_d;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] stat_w;
    logic        hold_ok_q, hold_ok_d;

    // fixed-zero positions are dropped so they always read back low
    always_comb begin
        prec_d = prec_q;
        opt_d = opt_q;
        aux_d = aux_q;
        rdata_d = 16'h0000;
        if (reg_wr) begin
            case (reg_addr)
                `SACR_OFS_PREC: prec_d = reg_wdata & `SACR_MASK_PREC;
                `SACR_OFS_OPT:  opt_d = reg_wdata & `SACR_MASK_OPT;
                `SACR_OFS_AUX:  aux_d = reg_wdata & `SACR_MASK_AUX;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `SACR_OFS_PREC: rdata_d = prec_q;
                `SACR_OFS_OPT:  rdata_d = opt_q;
                `SACR_OFS_AUX:  rdata_d = aux_q;
                `SACR_OFS_STAT: rdata_d = stat_w;
                default:        rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prec_q <= `SACR_RST_PREC;
            opt_q <= `SACR_RST_OPT;
            aux_q <= `SACR_RST_AUX;
            rdata_q <= 16'h0000;
        end else begin
            prec_q <= prec_d;
            opt_q <= opt_d;
            aux_q <= aux_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ---------------------------------------------------------------
    // filter precision and routing
    // ---------------------------------------------------------------
    // focus and tracking first and third stages
    assign focus_stage1_precise_normal = prec_q[`SACR_F1N];
    assign focus_stage1_precise_down = prec_q[`SACR_F1D];
    assign focus_stage3_precise_normal = prec_q[`SACR_F3N];
    assign focus_stage3_precise_down = prec_q[`SACR_F3D];
    assign track_stage1_precise_normal = prec_q[`SACR_T1N];
    assign track_stage1_precise_up = prec_q[`SACR_T1U];
    assign track_stage3_precise_normal = prec_q[`SACR_T3N];
    assign track_stage3_precise_up = prec_q[`SACR_T3U];
    assign focus_hold_src_addr = prec_q[`SACR_HSRC] ? `SACR_HOLD_ADDR_ALT
                                                     : `SACR_HOLD_ADDR_DEF;
    assign sled_src_from_track = aux_q[`SACR_SLSRC];
    assign trkhold_src_from_track = aux_q[`SACR_THSRC];
    assign center_correction_en = aux_q[`SACR_TCC]
                                  & ~(prec_q[`SACR_CMSK] & ~focus_ok);

    // ---------------------------------------------------------------
    // detector pin direction
    // ---------------------------------------------------------------
    logic mir_ext;
    logic all_ext;

    assign lock_eff = prec_q[`SACR_LKX] ? lock_pin_in : lock_int;
    assign lock_pin_out = lock_int;
    assign lock_pin_oe_n = prec_q[`SACR_LKX];
    assign cross_eff = prec_q[`SACR_COX] ? cross_pin_in : cross_int;
    assign cross_pin_out = cross_int;
    assign cross_pin_oe_n = prec_q[`SACR_COX];
    assign all_ext = prec_q[`SACR_ALLX];
    assign mir_ext = all_ext | prec_q[`SACR_MIRX];
    assign mirror_detect = mir_ext ? mirror_pin_in : mirror_int;
    assign defect_detect = all_ext ? defect_pin_in : defect_int;
    assign focus_ok = all_ext ? focus_ok_pin_in : focus_ok_int;
    assign mirror_pin_out = mirror_int;
    assign mirror_pin_oe_n = mir_ext;
    assign defect_pin_out = defect_int;
    assign defect_pin_oe_n = all_ext;
    assign focus_ok_pin_out = focus_ok_int;
    assign focus_ok_pin_oe_n = all_ext;

    // ---------------------------------------------------------------
    // servo master clock enable
    // ---------------------------------------------------------------
    sacr_div_t  ratio;
    logic [1:0] div_q, div_d;

    always_comb begin
        if (prec_q[`SACR_BYP]) begin
            ratio = SACR_DIV_1;
        end else if (opt_q[`SACR_DIV2]) begin
            ratio = SACR_DIV_2;
        end else if (opt_q[`SACR_DIV4]) begin
            ratio = SACR_DIV_4;
        end else begin
            ratio = clk_div_select_pin ? SACR_DIV_2 : SACR_DIV_1;
        end
    end

    always_comb begin
        case (ratio)
            SACR_DIV_1: servo_master_clk = 1'b1;
            SACR_DIV_2: servo_master_clk = div_q[0];
            SACR_DIV_4: servo_master_clk = &div_q;
            default:    servo_master_clk = 1'b1;
        endcase
        div_d = div_q + 2'd1;
    end

    assign clk_div_ratio = ratio;

    // ---------------------------------------------------------------
    // agc sine, focus search pacing
    // ---------------------------------------------------------------
    logic       sine_tog_q, sine_tog_d;
    logic [1:0] slope_q, slope_d;

    assign agc_focus_amp = amp_f(opt_q[`SACR_ALT], agc_focus_amp_sel, agc_track_amp_sel, 1'b0);
    assign agc_track_amp = amp_f(opt_q[`SACR_ALT], agc_focus_amp_sel, agc_track_amp_sel, 1'b1);

    always_comb begin
        sine_tog_d = sine_tog_q ^ servo_master_clk;
        slope_d = servo_master_clk ? slope_q + 2'd1 : slope_q;
        agc_sine_step = servo_master_clk & (~opt_q[`SACR_HALF] | sine_tog_q);
        search_step = servo_master_clk & (~opt_q[`SACR_SLQ] | (&slope_q));
    end

    // ---------------------------------------------------------------
    // data ram clear
    // ---------------------------------------------------------------
    logic [2:0]  clr_idx_q, clr_idx_d;
    logic [12:0] hold_cnt_q, hold_cnt_d;
    logic        clr_lo, clr_up, lo_held;

    // lower range cleared whenever SACR_CLRL is set, and with SACR_CLRLU only while unlocked
    assign clr_lo = opt_q[`SACR_CLRL] | (opt_q[`SACR_CLRLU] & ~lock_eff);
    assign clr_up = opt_q[`SACR_CLRU];
    assign lo_held = opt_q[`SACR_CLRL] | opt_q[`SACR_CLRLU];

    // index 0..2 walks the lower range, 3..5 the upper range
    always_comb begin
        clr_idx_d = (clr_idx_q == 3'd5) ? 3'd0 : clr_idx_q + 3'd1;
        if (clr_idx_q < 3'd3) begin
            ram_clr_we = clr_lo;
            ram_clr_addr = `SACR_RAM_LO_BASE + {4'h0, clr_idx_q[1:0]};
        end else begin
            ram_clr_we = clr_up;
            ram_clr_addr = `SACR_RAM_UP_BASE + {3'h0, clr_idx_q - 3'd3};
        end
        ram_clr_data = 16'h0000;
    end

    always_comb begin
        hold_cnt_d = hold_cnt_q;
        hold_ok_d = hold_ok_q;
        if (!lo_held) begin
            hold_cnt_d = 13'h0000;
        end else if (hold_cnt_q != CLR_HOLD_CYC[12:0]) begin
            hold_cnt_d = hold_cnt_q + 13'd1;
        end
        if (lo_held && hold_cnt_q == CLR_HOLD_CYC[12:0] - 13'd1) begin
            hold_ok_d = 1'b1;
        end else if (reg_wr && reg_addr == `SACR_OFS_OPT && lo_held
                     && !(reg_wdata[`SACR_CLRL] | reg_wdata[`SACR_CLRLU])
                     && hold_cnt_q != CLR_HOLD_CYC[12:0]) begin
            hold_ok_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= 2'b00;
            sine_tog_q <= 1'b0;
            slope_q <= 2'b00;
            clr_idx_q <= 3'd0;
            hold_cnt_q <= 13'h0000;
            hold_ok_q <= 1'b1;
        end else begin
            div_q <= div_d;
            sine_tog_q <= sine_tog_d;
            slope_q <= slope_d;
            clr_idx_q <= clr_idx_d;
            hold_cnt_q <= hold_cnt_d;
            hold_ok_q <= hold_ok_d;
        end
    end

    // ---------------------------------------------------------------
    // anti-shock, buffers, status
    // ---------------------------------------------------------------
    // force gain normal on shock
    assign focus_force_gain_normal = opt_q[`SACR_FGN] & shock_active & shock_detect;
    assign shared_buffer_low_power = opt_q[`SACR_LPW];
    // shock flag pin, high means vibration
    assign shock_flag_pin_out = shock_detect;
    assign shock_flag_pin_oe_n = ~aux_q[`SACR_SHOT];

    assign stat_w = {7'h00, hold_ok_q, clk_div_ratio, focus_ok, defect_detect,
                     mirror_detect, cross_eff, lock_eff, shock_detect};
endmodule

// *** bench/sacr_pins.sv ***
// board model of the five two-way detector pins
`timescale 1ns/10ps
module sacr_pins (
    // device side
    input  wire logic [4:0] oe_n,
    input  wire logic [4:0] drv,
    // external source
    input  wire logic [4:0] ext,
    output logic      [4:0] pin_in
);
    // ---------------------------------------------
    // wire level
    // ---------------------------------------------
    // the outside source only drives a pin the device has let go
    assign pin_in = (oe_n & ext) | (~oe_n & drv);
endmodule

// *** bench/sacr_asserts.sv ***
// concurrent checks on the servo option register ports
`timescale 1ns/10ps
module sacr_asserts #(
    parameter int CLR_HOLD_CYC = 20
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [15:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic [5:0]    focus_hold_src_addr,
    input  wire logic          lock_int,
    input  wire logic          lock_pin_in,
    input  wire logic          lock_pin_oe_n,
    input  wire logic          cross_pin_oe_n,
    input  wire logic          mirror_pin_oe_n,
    input  wire logic          defect_pin_oe_n,
    input  wire logic          lock_eff,
    input  sacr_pkg::sacr_div_t clk_div_ratio,
    input  wire logic          servo_master_clk,
    input  sacr_pkg::sacr_amp_t agc_focus_amp,
    input  sacr_pkg::sacr_amp_t agc_track_amp,
    input  wire logic          agc_sine_step,
    input  wire logic          search_step,
    input  wire logic          ram_clr_we,
    input  wire logic [5:0]    ram_clr_addr,
    input  wire logic [15:0]   ram_clr_data,
    input  wire logic          shock_active,
    input  wire logic          shock_detect,
    input  wire logic          focus_force_gain_normal,
    input  wire logic          shock_flag_pin_out,
    input  wire logic          shock_flag_pin_oe_n
);
    import sacr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence wr_prec; reg_wr && reg_addr == 8'h3e; endsequence
    sequence wr_aux; reg_wr && reg_addr == 8'h40; endsequence
    sequence mck_quarter; servo_master_clk && clk_div_ratio == SACR_DIV_4; endsequence
    chk_hold_src_addr: assert property (
        wr_prec |=> focus_hold_src_addr == ($past(reg_wdata[7]) ? 6'h04 : 6'h05))
        else $error("hold source address wrong");
    chk_lock_cross_dir: assert property (
        wr_prec |=> lock_pin_oe_n == $past(reg_wdata[4]) && cross_pin_oe_n == $past(reg_wdata[3]))
        else $error("lock or cross-count pin direction wrong");
    chk_lock_select: assert property (
        lock_eff == (lock_pin_oe_n ? lock_pin_in : lock_int))
        else $error("lock source wrong");
    chk_detect_dir: assert property (
        wr_prec |=> mirror_pin_oe_n == $past(reg_wdata[2] | reg_wdata[1])
                    && defect_pin_oe_n == $past(reg_wdata[2]))
        else $error("detector pin direction wrong");
    chk_undivided_clk: assert property (
        clk_div_ratio == SACR_DIV_1 |-> servo_master_clk)
        else $error("undivided clock missed a cycle");
    chk_quarter_gap: assert property (
        mck_quarter |=> (!servo_master_clk || clk_div_ratio != SACR_DIV_4) [*3])
        else $error("quarter clock pulse too early");
    chk_ram_clear: assert property (
        ram_clr_we |-> ram_clr_data == 16'h0000
                       && ram_clr_addr inside {6'h00, 6'h01, 6'h02, 6'h08, 6'h09, 6'h0a})
        else $error("ram clear write wrong");
    chk_force_gain: assert property (
        focus_force_gain_normal |-> shock_active && shock_detect)
        else $error("gain forced without shock");
    chk_step_enable: assert property (
        agc_sine_step || search_step |-> servo_master_clk)
        else $error("step outside master clock");
    chk_amp_common: assert property (
        agc_focus_amp inside {SACR_AMP_1_64, SACR_AMP_1_32} |-> agc_track_amp == agc_focus_amp)
        else $error("alternate amplitude not common");
    chk_amp_default: assert property (
        agc_focus_amp == SACR_AMP_1_36 |-> agc_track_amp inside {SACR_AMP_1_16, SACR_AMP_1_8})
        else $error("default track amplitude wrong");
    chk_shock_pin: assert property (
        wr_aux |=> shock_flag_pin_oe_n == !$past(reg_wdata[0]) && shock_flag_pin_out == shock_detect)
        else $error("shock pin wrong");
endmodule

bind sacr_top sacr_asserts #(.CLR_HOLD_CYC(CLR_HOLD_CYC)) u_chk (
    .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .focus_hold_src_addr, .lock_int,
    .lock_pin_in, .lock_pin_oe_n, .cross_pin_oe_n, .mirror_pin_oe_n, .defect_pin_oe_n,
    .lock_eff, .clk_div_ratio, .servo_master_clk, .agc_focus_amp, .agc_track_amp,
    .agc_sine_step, .search_step, .ram_clr_we, .ram_clr_addr, .ram_clr_data,
    .shock_active, .shock_detect, .focus_force_gain_normal, .shock_flag_pin_out,
    .shock_flag_pin_oe_n
);

// *** bench/servo_aux_config_registers_bench.sv ***
// self-checking bench of the servo option registers
`timescale 1ns/10ps
module servo_aux_config_registers_bench;
    import sacr_pkg::*;
    logic clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, ram_clr_data;
    logic lock_int = 1'h1, cross_int = 1'h1, mirror_int = 1'h1, defect_int = 1'h1;
    logic focus_ok_int = 1'h1, clk_div_select_pin = 1'h0;
    logic agc_focus_amp_sel = 1'h0, agc_track_amp_sel = 1'h0;
    logic shock_active = 1'h0, shock_detect = 1'h0;
    logic focus_stage1_precise_normal, focus_stage1_precise_down, focus_stage3_precise_normal;
    logic focus_stage3_precise_down, track_stage1_precise_normal, track_stage1_precise_up;
    logic track_stage3_precise_normal, track_stage3_precise_up, sled_src_from_track;
    logic trkhold_src_from_track, center_correction_en, lock_pin_out, lock_pin_oe_n;
    logic cross_pin_out, cross_pin_oe_n, mirror_pin_out, mirror_pin_oe_n, defect_pin_out;
    logic defect_pin_oe_n, focus_ok_pin_out, focus_ok_pin_oe_n, lock_eff, cross_eff;
    logic mirror_detect, defect_detect, focus_ok, servo_master_clk, agc_sine_step;
    logic ram_clr_we, focus_force_gain_normal, search_step, shared_buffer_low_power;
    logic shock_flag_pin_out, shock_flag_pin_oe_n;
    logic [5:0] focus_hold_src_addr, ram_clr_addr;
    wire lock_pin_in, cross_pin_in, mirror_pin_in, defect_pin_in, focus_ok_pin_in;
    sacr_div_t clk_div_ratio;
    sacr_amp_t agc_focus_amp, agc_track_amp;
    sacr_amp_t amp_tab [4] = '{SACR_AMP_1_64, SACR_AMP_1_32, SACR_AMP_1_16, SACR_AMP_1_8};
    int errors = 0, samples_checked = 0, n_mck, n_agc, n_srch, n_lo, n_up;
    wire [4:0] oe_v = {lock_pin_oe_n, cross_pin_oe_n, mirror_pin_oe_n, defect_pin_oe_n,
                       focus_ok_pin_oe_n};
    wire [4:0] eff_v = {lock_eff, cross_eff, mirror_detect, defect_detect, focus_ok};
    wire [7:0] prec_v = {focus_stage1_precise_normal, focus_stage1_precise_down,
                         focus_stage3_precise_normal, focus_stage3_precise_down,
                         track_stage1_precise_normal, track_stage1_precise_up,
                         track_stage3_precise_normal, track_stage3_precise_up};

    always #5 clk = ~clk;

    // short hold count keeps the clear hold test brief
    sacr_top #(.CLR_HOLD_CYC(20)) u_dut (.*);
    // outside source holds every pin low, opposite to the internal signals
    sacr_pins u_pins (
        .oe_n   (oe_v),
        .drv    ({lock_pin_out, cross_pin_out, mirror_pin_out, defect_pin_out, focus_ok_pin_out}),
        .ext    (5'h00),
        .pin_in ({lock_pin_in, cross_pin_in, mirror_pin_in, defect_pin_in, focus_ok_pin_in})
    );

    // --------------------------------------------------
    // pulse counters and tasks
    // --------------------------------------------------
    always @(posedge clk) begin
        n_mck += servo_master_clk;
        n_agc += agc_sine_step;
        n_srch += search_step;
        n_lo += ram_clr_we && ram_clr_addr <= 6'h02;
        n_up += ram_clr_we && ram_clr_addr >= 6'h08;
    end
    task automatic run(input int n);
        @(negedge clk);
        {n_mck, n_agc, n_srch, n_lo, n_up} = '0;
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #500us;
        errors++;
        results;
    end

    // --------------------------------------------------
    // scenarios
    // --------------------------------------------------
    initial begin
        logic [15:0] d;
        logic [4:0] e5;
        sacr_div_t ed;
        sacr_amp_t ef, et;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        for (int a = 8'h3e; a < 8'h41; a++) begin
            rd(8'(a), d);
            chk(d, 16'h0000);
        end
        wr(8'h3e, 16'hffff);
        rd(8'h3e, d);
        chk(d, 16'hffdf);
        wr(8'h3f, 16'h888d);
        rd(8'h3f, d);
        chk(d, 16'h0000);
        for (int b = 8; b < 16; b++) begin
            wr(8'h3e, 16'h0001 << b);
            chk(16'(prec_v), 16'h0001 << (b - 8));
        end
        wr(8'h3e, 16'h0080);
        chk(16'(focus_hold_src_addr), 16'h0004);
        for (int i = 0; i < 16; i++) begin
            wr(8'h3e, {11'h000, i[3:0], 1'h0});
            e5 = {i[3], i[2], i[1] | i[0], i[1], i[1]};
            chk(16'(oe_v), 16'(e5));
            chk(16'(eff_v), {11'h000, ~e5});
        end
        wr(8'h3e, 16'h0000);
        chk(16'(focus_hold_src_addr), 16'h0005);
        // correction masked only while focus is not ok
        wr(8'h40, 16'h0008);
        wr(8'h3e, 16'h0040);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) focus_ok_int <= i[0];
            #1 chk(center_correction_en, 16'(i[0]));
        end
        wr(8'h3e, 16'h0000);
        @(posedge clk) focus_ok_int <= 1'h0;
        #1 chk(center_correction_en, 16'h0001);
        focus_ok_int <= 1'h1;
        for (int i = 0; i < 16; i++) begin
            wr(8'h3e, {15'h0000, i[3]});
            wr(8'h3f, {2'h0, i[1], i[2], 12'h000});
            @(posedge clk) clk_div_select_pin <= i[0];
            #1;
            ed = i[3] ? SACR_DIV_1 : i[2] ? SACR_DIV_2 : i[1] ? SACR_DIV_4 :
                 i[0] ? SACR_DIV_2 : SACR_DIV_1;
            chk(16'(clk_div_ratio), 16'(ed));
            run(4);
            run(8);
            chk(16'(n_mck), 16'(8 >> ed));
        end
        for (int i = 0; i < 8; i++) begin
            wr(8'h3f, {1'h0, i[2], 14'h0000});
            @(posedge clk) {agc_focus_amp_sel, agc_track_amp_sel} <= i[1:0];
            #1;
            ef = i[2] ? amp_tab[i[1:0]] : (i[1] ? SACR_AMP_1_16 : SACR_AMP_1_36);
            et = i[2] ? amp_tab[i[1:0]] : (i[0] ? SACR_AMP_1_8 : SACR_AMP_1_16);
            chk({10'h000, agc_focus_amp, agc_track_amp}, {10'h000, ef, et});
        end
        wr(8'h3f, 16'h0000);
        run(16);
        chk(16'(n_agc), 16'h0010);
        chk(16'(n_srch), 16'h0010);
        wr(8'h3f, 16'h0022);
        run(16);
        chk(16'(n_agc), 16'h0008);
        chk(16'(n_srch), 16'h0004);
        wr(8'h3f, 16'h0010);
        chk(shared_buffer_low_power, 16'h0001);
        // ram clears; the lower range under SACR_CLRLU waits for lock low
        wr(8'h3f, 16'h0400);
        run(12);
        chk(16'(n_up), 16'h0006);
        chk(16'(n_lo), 16'h0000);
        wr(8'h3f, 16'h0100);
        run(12);
        chk(16'(n_lo), 16'h0000);
        lock_int <= 1'h0;
        run(12);
        chk(16'(n_lo), 16'h0006);
        wr(8'h3f, 16'h0000);
        wr(8'h3f, 16'h0200);
        run(5);
        wr(8'h3f, 16'h0000);
        rd(8'h41, d);
        chk(16'(d[8]), 16'h0000);
        wr(8'h3f, 16'h0200);
        run(24);
        chk(16'(n_lo), 16'h000c);
        wr(8'h3f, 16'h0000);
        rd(8'h41, d);
        chk(16'(d[8]), 16'h0001);
        wr(8'h3f, 16'h0040);
        @(posedge clk) {shock_active, shock_detect} <= 2'h3;
        #1 chk(focus_force_gain_normal, 16'h0001);
        wr(8'h3f, 16'h0000);
        chk(focus_force_gain_normal, 16'h0000);
        wr(8'h40, 16'h0007);
        chk({shock_flag_pin_oe_n, shock_flag_pin_out}, 16'h0001);
        chk({sled_src_from_track, trkhold_src_from_track}, 16'h0003);
        wr(8'h55, 16'hffff);
        rd(8'h55, d);
        chk(d, 16'h0000);
        results;
    end
endmodule
